// File: design/jtl_tap.sv
// Boundary-scan test access port with a user data word exchanged with the system clock domain
module jtl_tap (
  input  wire logic        clk_sys_i,        // System clock, 125 MHz
  input  wire logic        reset_i,          // System reset, sync, active high
  input  wire logic        tck_i,            // Test clock from the controller
  input  wire logic        trst_n_i,         // Test reset, async, active low
  input  wire logic        tms_i,            // Test mode select
  input  wire logic        tdi_i,            // Serial test data in
  output logic             tdo_o,            // Serial test data out
  output logic             tdo_oe_o,         // Test data out driven when high
  input  wire logic [31:0] sys_cap_word_i,   // Word offered to the scan chain
  input  wire logic        sys_cap_load_i,   // Pulse: take sys_cap_word_i as the offered word
  output logic             sys_cap_busy_o,   // High until the offered word reached the test side
  output logic [31:0]      sys_upd_word_o,   // Last word written in by the controller
  output logic             sys_upd_stb_o     // Pulse: sys_upd_word_o has just changed
);

  // ---------------------------------------------------------------
  // Test clock domain
  // ---------------------------------------------------------------
  jtl_pkg::jtl_state_t state;

  jtl_tap_fsm u_fsm (
    .tck_i    (tck_i),
    .trst_n_i (trst_n_i),
    .tms_i    (tms_i),
    .state_o  (state)
  );

  logic [jtl_pkg::IR_W-1:0] ir_shift_ff;
  logic [jtl_pkg::IR_W-1:0] ir_ff;
  logic [jtl_pkg::DR_W-1:0] dr_shift_ff;
  logic                     bypass_ff;
  logic [jtl_pkg::DR_W-1:0] upd_word_ff;
  logic                     upd_tgl_ff;
  logic [jtl_pkg::DR_W-1:0] cap_hold_ff;
  logic                     cap_seen_ff;

  logic [jtl_pkg::IR_W-1:0] nxt_ir_shift;
  logic [jtl_pkg::IR_W-1:0] nxt_ir;
  logic [jtl_pkg::DR_W-1:0] nxt_dr_shift;
  logic                     nxt_bypass;
  logic [jtl_pkg::DR_W-1:0] nxt_upd_word;
  logic                     nxt_upd_tgl;
  logic [jtl_pkg::DR_W-1:0] nxt_cap_hold;
  logic                     nxt_cap_seen;

  logic tdo_ff;
  logic tdo_oe_ff;
  logic nxt_tdo;
  logic nxt_tdo_oe;

  logic sys_cap_tgl_ff;
  logic [jtl_pkg::DR_W-1:0] sys_cap_word_ff;
  logic cap_tgl_sync;

  logic sel_idcode;
  logic sel_user;

  // Offer toggle from the system side, brought onto the test clock
  jtl_sync2 u_cap_sync (
    .clk_i    (tck_i),
    .arst_n_i (trst_n_i),
    .d_i      (sys_cap_tgl_ff),
    .q_o      (cap_tgl_sync)
  );

  assign sel_idcode = (ir_ff == jtl_pkg::OP_IDCODE);
  assign sel_user   = (ir_ff == jtl_pkg::OP_USERDATA);

  always_comb begin
    nxt_ir_shift = ir_shift_ff;
    nxt_ir       = ir_ff;
    nxt_dr_shift = dr_shift_ff;
    nxt_bypass   = bypass_ff;
    nxt_upd_word = upd_word_ff;
    nxt_upd_tgl  = upd_tgl_ff;

    unique case (state)
      jtl_pkg::ST_TEST_RESET: begin
        nxt_ir = jtl_pkg::IR_RESET;
      end
      jtl_pkg::ST_CAPTURE_IR: begin
        nxt_ir_shift = jtl_pkg::IR_CAPTURE;
      end
      jtl_pkg::ST_SHIFT_IR: begin
        nxt_ir_shift = {tdi_i, ir_shift_ff[jtl_pkg::IR_W-1:1]};
      end
      jtl_pkg::ST_UPDATE_IR: begin
        nxt_ir = ir_shift_ff;
      end
      jtl_pkg::ST_CAPTURE_DR: begin
        nxt_bypass = 1'b0;
        if (sel_idcode) begin
          nxt_dr_shift = jtl_pkg::IDCODE_VAL;
        end else if (sel_user) begin
          nxt_dr_shift = cap_hold_ff;
        end
      end
      jtl_pkg::ST_SHIFT_DR: begin
        if (sel_idcode || sel_user) begin
          nxt_dr_shift = {tdi_i, dr_shift_ff[jtl_pkg::DR_W-1:1]};
        end else begin
          nxt_bypass = tdi_i;
        end
      end
      jtl_pkg::ST_UPDATE_DR: begin
        // Only the user word has an effect outside the scan chain
        if (sel_user) begin
          nxt_upd_word = dr_shift_ff;
          nxt_upd_tgl  = ~upd_tgl_ff;
        end
      end
      default: begin
      end
    endcase
  end

  // Nothing here is clocked by anything but the test clock, so a stopped
  // clock leaves every stored bit as it is
  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      ir_shift_ff <= jtl_pkg::IR_CAPTURE;
      ir_ff       <= jtl_pkg::IR_RESET;
      dr_shift_ff <= jtl_pkg::WORD_RESET;
      bypass_ff   <= 1'b0;
      upd_word_ff <= jtl_pkg::WORD_RESET;
      upd_tgl_ff  <= 1'b0;
    end else begin
      ir_shift_ff <= nxt_ir_shift;
      ir_ff       <= nxt_ir;
      dr_shift_ff <= nxt_dr_shift;
      bypass_ff   <= nxt_bypass;
      upd_word_ff <= nxt_upd_word;
      upd_tgl_ff  <= nxt_upd_tgl;
    end
  end

  // Offer copy. The offered word stays frozen while the toggles differ, so it
  // may be copied across here without tearing
  always_comb begin
    nxt_cap_hold = cap_hold_ff;
    nxt_cap_seen = cap_seen_ff;
    if (cap_tgl_sync != cap_seen_ff) begin
      nxt_cap_hold = sys_cap_word_ff;
      nxt_cap_seen = cap_tgl_sync;
    end
  end

  // A test reset empties the copy; if the offer toggle is high, busy then shows again on the system side
  // until the test clock runs and the same word is copied anew; if it is low, the copy stays empty
  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      cap_hold_ff <= jtl_pkg::WORD_RESET;
      cap_seen_ff <= 1'b0;
    end else begin
      cap_hold_ff <= nxt_cap_hold;
      cap_seen_ff <= nxt_cap_seen;
    end
  end

  // Falling-edge output stage: half a period of hold for the controller
  always_comb begin
    nxt_tdo    = tdo_ff;
    nxt_tdo_oe = 1'b0;
    unique case (state)
      jtl_pkg::ST_SHIFT_IR: begin
        nxt_tdo    = ir_shift_ff[0];
        nxt_tdo_oe = 1'b1;
      end
      jtl_pkg::ST_SHIFT_DR: begin
        nxt_tdo    = (sel_idcode || sel_user) ? dr_shift_ff[0] : bypass_ff;
        nxt_tdo_oe = 1'b1;
      end
      default: begin
      end
    endcase
  end

  always_ff @(negedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      tdo_ff    <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else begin
      tdo_ff    <= nxt_tdo;
      tdo_oe_ff <= nxt_tdo_oe;
    end
  end

  assign tdo_o    = tdo_ff;
  assign tdo_oe_o = tdo_oe_ff;

  // ---------------------------------------------------------------
  // System clock domain
  // ---------------------------------------------------------------
  logic upd_meta_ff;
  logic upd_sync_ff;
  logic upd_late_ff;
  logic upd_seen_ff;
  logic trst_meta_ff;
  logic trst_sync_ff;
  logic cap_ack_meta_ff;
  logic cap_ack_sync_ff;
  logic [jtl_pkg::DR_W-1:0] sys_upd_word_ff;
  logic sys_upd_stb_ff;

  logic nxt_upd_seen;
  logic [jtl_pkg::DR_W-1:0] nxt_sys_upd_word;
  logic nxt_sys_upd_stb;
  logic nxt_sys_cap_tgl;
  logic [jtl_pkg::DR_W-1:0] nxt_sys_cap_word;
  logic cap_busy;

  // Busy while the test side has not yet echoed the offer toggle; a load
  // during busy is dropped so the word in flight never changes
  assign cap_busy = (sys_cap_tgl_ff != cap_ack_sync_ff);

  // Update path. A test reset clears the update toggle as well; the test
  // reset level shows here a cycle before the late toggle stage does, so that
  // change is followed without a strobe and the last written word stays.
  // Limitation: a test reset pulse must span a few system cycles for this.
  always_comb begin
    nxt_upd_seen     = upd_seen_ff;
    nxt_sys_upd_word = sys_upd_word_ff;
    nxt_sys_upd_stb  = 1'b0;
    // upd_word_ff has been still for three system cycles by the time the
    // toggle shows here; a new update needs far longer than that
    if (upd_late_ff != upd_seen_ff) begin
      nxt_upd_seen = upd_late_ff;
      if (trst_sync_ff) begin
        nxt_sys_upd_word = upd_word_ff;
        nxt_sys_upd_stb  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      upd_meta_ff     <= 1'b0;
      upd_sync_ff     <= 1'b0;
      upd_late_ff     <= 1'b0;
      upd_seen_ff     <= 1'b0;
      trst_meta_ff    <= 1'b0;
      trst_sync_ff    <= 1'b0;
      sys_upd_word_ff <= jtl_pkg::WORD_RESET;
      sys_upd_stb_ff  <= 1'b0;
    end else begin
      upd_meta_ff     <= upd_tgl_ff;
      upd_sync_ff     <= upd_meta_ff;
      upd_late_ff     <= upd_sync_ff;
      upd_seen_ff     <= nxt_upd_seen;
      trst_meta_ff    <= trst_n_i;
      trst_sync_ff    <= trst_meta_ff;
      sys_upd_word_ff <= nxt_sys_upd_word;
      sys_upd_stb_ff  <= nxt_sys_upd_stb;
    end
  end

  // Offer path
  always_comb begin
    nxt_sys_cap_tgl  = sys_cap_tgl_ff;
    nxt_sys_cap_word = sys_cap_word_ff;
    if (sys_cap_load_i && !cap_busy) begin
      nxt_sys_cap_word = sys_cap_word_i;
      nxt_sys_cap_tgl  = ~sys_cap_tgl_ff;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cap_ack_meta_ff <= 1'b0;
      cap_ack_sync_ff <= 1'b0;
      sys_cap_tgl_ff  <= 1'b0;
      sys_cap_word_ff <= jtl_pkg::WORD_RESET;
    end else begin
      cap_ack_meta_ff <= cap_seen_ff;
      cap_ack_sync_ff <= cap_ack_meta_ff;
      sys_cap_tgl_ff  <= nxt_sys_cap_tgl;
      sys_cap_word_ff <= nxt_sys_cap_word;
    end
  end

  assign sys_upd_word_o = sys_upd_word_ff;
  assign sys_upd_stb_o  = sys_upd_stb_ff;
  assign sys_cap_busy_o = cap_busy;

endmodule : jtl_tap

// File: design/jtl_pkg.sv
// Constants, opcodes and state codes for the boundary-scan test access port
// What this block does
// - A low test reset asynchronously resets all test port logic, whatever the test clock does.
// - Mode select steers the controller state machine, sampled on each test clock rise.
// - Instructions and data shift in serially from test data input on rising edges.
// - Test data output changes on the falling test clock edge, for sampling on next rise.
// - Test data output is high impedance except while shifting data or instruction out.
// - With test clock stopped low, every test logic storage element keeps its state.
package jtl_pkg;

  localparam int unsigned IR_W = 4;
  localparam int unsigned DR_W = 32;

  // Instruction opcodes; any code not listed acts as bypass
  localparam logic [IR_W-1:0] OP_IDCODE   = 4'h1;
  localparam logic [IR_W-1:0] OP_USERDATA = 4'h3;
  localparam logic [IR_W-1:0] OP_BYPASS   = 4'hf;

  // Fixed pattern loaded into the instruction shifter at capture
  localparam logic [IR_W-1:0] IR_CAPTURE  = 4'h1;
  // Instruction in force after test logic reset
  localparam logic [IR_W-1:0] IR_RESET    = OP_IDCODE;

  // Identification word; the value is arbitrary, bit 0 must stay set
  localparam logic [DR_W-1:0] IDCODE_VAL  = 32'h0000_0001;

  localparam logic [DR_W-1:0] WORD_RESET  = 32'h0000_0000;

  typedef enum logic [3:0] {
    ST_EXIT2_DR   = 4'b0000,
    ST_EXIT1_DR   = 4'b0001,
    ST_SHIFT_DR   = 4'b0010,
    ST_PAUSE_DR   = 4'b0011,
    ST_SELECT_IR  = 4'b0100,
    ST_UPDATE_DR  = 4'b0101,
    ST_CAPTURE_DR = 4'b0110,
    ST_SELECT_DR  = 4'b0111,
    ST_EXIT2_IR   = 4'b1000,
    ST_EXIT1_IR   = 4'b1001,
    ST_SHIFT_IR   = 4'b1010,
    ST_PAUSE_IR   = 4'b1011,
    ST_RUN_IDLE   = 4'b1100,
    ST_UPDATE_IR  = 4'b1101,
    ST_CAPTURE_IR = 4'b1110,
    ST_TEST_RESET = 4'b1111
  } jtl_state_t;

endpackage : jtl_pkg

// File: design/jtl_sync2.sv
// Two-stage level synchroniser into the test clock domain
module jtl_sync2 (
  input  wire logic clk_i,     // Destination clock
  input  wire logic arst_n_i,  // Async reset, active low
  input  wire logic d_i,       // Level from the other domain
  output logic      q_o        // Synchronised level
);

  logic meta_ff;
  logic sync_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;

endmodule : jtl_sync2

// File: design/jtl_tap_fsm.sv
// Sixteen-state test access port controller
module jtl_tap_fsm (
  input  wire logic        tck_i,     // Test clock
  input  wire logic        trst_n_i,  // Test reset, async, active low
  input  wire logic        tms_i,     // Test mode select
  output jtl_pkg::jtl_state_t state_o // Current controller state
);

  jtl_pkg::jtl_state_t state_ff;
  jtl_pkg::jtl_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      jtl_pkg::ST_TEST_RESET: nxt_state = tms_i ? jtl_pkg::ST_TEST_RESET : jtl_pkg::ST_RUN_IDLE;
      jtl_pkg::ST_RUN_IDLE:   nxt_state = tms_i ? jtl_pkg::ST_SELECT_DR  : jtl_pkg::ST_RUN_IDLE;
      jtl_pkg::ST_SELECT_DR:  nxt_state = tms_i ? jtl_pkg::ST_SELECT_IR  : jtl_pkg::ST_CAPTURE_DR;
      jtl_pkg::ST_CAPTURE_DR: nxt_state = tms_i ? jtl_pkg::ST_EXIT1_DR   : jtl_pkg::ST_SHIFT_DR;
      jtl_pkg::ST_SHIFT_DR:   nxt_state = tms_i ? jtl_pkg::ST_EXIT1_DR   : jtl_pkg::ST_SHIFT_DR;
      jtl_pkg::ST_EXIT1_DR:   nxt_state = tms_i ? jtl_pkg::ST_UPDATE_DR  : jtl_pkg::ST_PAUSE_DR;
      jtl_pkg::ST_PAUSE_DR:   nxt_state = tms_i ? jtl_pkg::ST_EXIT2_DR   : jtl_pkg::ST_PAUSE_DR;
      jtl_pkg::ST_EXIT2_DR:   nxt_state = tms_i ? jtl_pkg::ST_UPDATE_DR  : jtl_pkg::ST_SHIFT_DR;
      jtl_pkg::ST_UPDATE_DR:  nxt_state = tms_i ? jtl_pkg::ST_SELECT_DR  : jtl_pkg::ST_RUN_IDLE;
      jtl_pkg::ST_SELECT_IR:  nxt_state = tms_i ? jtl_pkg::ST_TEST_RESET : jtl_pkg::ST_CAPTURE_IR;
      jtl_pkg::ST_CAPTURE_IR: nxt_state = tms_i ? jtl_pkg::ST_EXIT1_IR   : jtl_pkg::ST_SHIFT_IR;
      jtl_pkg::ST_SHIFT_IR:   nxt_state = tms_i ? jtl_pkg::ST_EXIT1_IR   : jtl_pkg::ST_SHIFT_IR;
      jtl_pkg::ST_EXIT1_IR:   nxt_state = tms_i ? jtl_pkg::ST_UPDATE_IR  : jtl_pkg::ST_PAUSE_IR;
      jtl_pkg::ST_PAUSE_IR:   nxt_state = tms_i ? jtl_pkg::ST_EXIT2_IR   : jtl_pkg::ST_PAUSE_IR;
      jtl_pkg::ST_EXIT2_IR:   nxt_state = tms_i ? jtl_pkg::ST_UPDATE_IR  : jtl_pkg::ST_SHIFT_IR;
      jtl_pkg::ST_UPDATE_IR:  nxt_state = tms_i ? jtl_pkg::ST_SELECT_DR  : jtl_pkg::ST_RUN_IDLE;
    endcase
  end

  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      state_ff <= jtl_pkg::ST_TEST_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign state_o = state_ff;

endmodule : jtl_tap_fsm

// File: verification/jtl_tap_monitor.sv
// Port checker for the test access port, bound into jtl_tap
module jtl_tap_monitor (
  input wire logic clk_sys_i,      // System clock
  input wire logic reset_i,        // System reset
  input wire logic tck_i,          // Test clock
  input wire logic trst_n_i,       // Test reset
  input wire logic tms_i,          // Mode select
  input wire logic tdo_o,          // Serial out
  input wire logic tdo_oe_o,       // Serial out enable
  input wire logic sys_cap_load_i, // Offer pulse
  input wire logic sys_cap_busy_o, // Offer pending
  input wire logic [31:0] sys_upd_word_o, // Written word
  input wire logic sys_upd_stb_o   // Written pulse
);
  sequence five_ones;
    tms_i [*5];
  endsequence
  sequence shift_leave;
    tdo_oe_o && tms_i;
  endsequence

  chk_trst_quiet: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !trst_n_i |-> !tdo_oe_o && !tdo_o) else $error("tdo active in test reset");
  chk_tdo_fall_only: assert property (@(posedge clk_sys_i) disable iff (reset_i || !trst_n_i)
    tck_i && $past(tck_i) |-> $stable(tdo_o) && $stable(tdo_oe_o)) else $error("tdo moved while tck high");
  chk_idle_retain: assert property (@(posedge clk_sys_i) disable iff (reset_i || !trst_n_i)
    !tck_i && !$past(tck_i) |-> $stable(tdo_o) && $stable(tdo_oe_o)) else $error("tdo moved while tck idle");
  chk_exit_release: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    shift_leave |=> !tdo_oe_o) else $error("tdo still driven after shift");
  chk_tlr_quiet: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    five_ones |=> !tdo_oe_o [*3]) else $error("tdo driven too soon after five ones");
  chk_oe_after_low: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    $rose(tdo_oe_o) |-> !$past(tms_i)) else $error("shift entered without mode low");
  chk_stb_single: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    sys_upd_stb_o |=> !sys_upd_stb_o) else $error("update strobe longer than one cycle");
  chk_word_with_stb: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !$stable(sys_upd_word_o) |-> sys_upd_stb_o) else $error("update word changed without strobe");
  chk_busy_take: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    sys_cap_load_i && !sys_cap_busy_o |=> sys_cap_busy_o) else $error("offer not taken");
  chk_busy_cause: assert property (@(posedge clk_sys_i) disable iff (reset_i || !trst_n_i)
    $rose(sys_cap_busy_o) |-> $past(sys_cap_load_i)) else $error("busy without offer");
endmodule : jtl_tap_monitor

bind jtl_tap jtl_tap_monitor jtl_tap_monitor_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .tck_i(tck_i),
  .trst_n_i(trst_n_i), .tms_i(tms_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .sys_cap_load_i(sys_cap_load_i),
  .sys_cap_busy_o(sys_cap_busy_o), .sys_upd_word_o(sys_upd_word_o), .sys_upd_stb_o(sys_upd_stb_o));

// File: verification/jtl_host.sv
// Behavioural boundary-scan controller driving the test port
module jtl_host (
  output logic      tck_o,    // Test clock, low between frames
  output logic      tms_o,    // Mode select
  output logic      tdi_o,    // Serial data to device
  output logic      trst_n_o, // Test reset
  input  wire logic tdo_i     // Resolved serial pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic gap_en = 1'b0;
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
    // Start high so the port sees a real falling edge of its test reset
    trst_n_o = 1'b1;
    #1 trst_n_o = 1'b0;
  end
  // One tck cycle; tdo is taken just before the rise, a full half period after the fall
  task step(input logic m, input logic d, output logic q);
    tms_o = m;
    tdi_o = d;
    #15 q = tdo_i;
    tck_o = 1'b1;
    #15 tck_o = 1'b0;
  endtask : step
  task drop;
    trst_n_o = 1'b0;
  endtask : drop
  task reset_tap;
    logic q;
    tms_o = 1'b1;
    trst_n_o = 1'b0;
    #40 trst_n_o = 1'b1;
    #20 step(1'b0, 1'b1, q);
  endtask : reset_tap
  // From run-idle, scan n bits LSB first and return to run-idle
  task scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b1, q);
    if (ir) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
      if (gap_en && i == 7) #500;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask : scan
endmodule : jtl_host

// File: verification/jtl_tap_tb.sv
// Self-checking testbench for the test access port
module jtl_tap_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        sys_cap_load_i = 1'b0;
  logic [31:0] sys_cap_word_i = 32'h0;
  wire         tck, tms, tdi, trst_n, tdo, tdo_oe, busy, stb;
  wire  [31:0] upd;
  wire         tdo_w = tdo_oe ? tdo : 1'bz;
  int          failures = 0;
  int          checks_done = 0;
  logic [31:0] q;
  logic        b;

  always #4 clk_sys_i = ~clk_sys_i;

  jtl_tap jtl_tap_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .tck_i(tck), .trst_n_i(trst_n), .tms_i(tms),
    .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .sys_cap_word_i(sys_cap_word_i),
    .sys_cap_load_i(sys_cap_load_i), .sys_cap_busy_o(busy), .sys_upd_word_o(upd), .sys_upd_stb_o(stb));
  jtl_host jtl_host_i (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n), .tdo_i(tdo_w));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task complete_run;
    $display("checks=%0d mismatches=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  task test_idcode;
    jtl_host_i.scan(1'b0, 32, 32'hffff_ffff, q);
    chk(q, jtl_pkg::IDCODE_VAL);
    chk({31'h0, tdo_w}, {31'h0, 1'bz});
    $display("test idcode done");
  endtask : test_idcode

  // Listed bypass code and an unlisted one both give a one-bit path
  task test_bypass;
    for (int k = 0; k < 2; k++) begin
      jtl_host_i.scan(1'b1, 4, {28'h0, k ? 4'h7 : jtl_pkg::OP_BYPASS}, q);
      chk({28'h0, q[3:0]}, {28'h0, jtl_pkg::IR_CAPTURE});
      jtl_host_i.scan(1'b0, 8, 32'ha5, q);
      chk({24'h0, q[7:0]}, 32'h4a);
    end
    $display("test bypass done");
  endtask : test_bypass

  // Second offer arrives while busy and must be dropped
  task test_user;
    @(posedge clk_sys_i) #1;
    sys_cap_word_i = 32'hc001_d00d;
    sys_cap_load_i = 1'b1;
    @(posedge clk_sys_i) #1;
    sys_cap_word_i = 32'h0bad_f00d;
    @(posedge clk_sys_i) #1;
    sys_cap_load_i = 1'b0;
    chk({31'h0, busy}, 32'h1);
    for (int i = 0; i < 20 && busy !== 1'b0; i++) jtl_host_i.step(1'b0, 1'b1, b);
    chk({31'h0, busy}, 32'h0);
    jtl_host_i.scan(1'b1, 4, {28'h0, jtl_pkg::OP_USERDATA}, q);
    jtl_host_i.gap_en = 1'b1;
    jtl_host_i.scan(1'b0, 32, 32'h1234_abcd, q);
    jtl_host_i.gap_en = 1'b0;
    chk(q, 32'hc001_d00d);
    b = 1'b0;
    for (int i = 0; i < 20 && b !== 1'b1; i++) begin
      @(negedge clk_sys_i);
      b = stb;
    end
    chk({31'h0, b}, 32'h1);
    chk(upd, 32'h1234_abcd);
    $display("test user word done");
  endtask : test_user

  // Test reset in the middle of a data shift
  task test_trst_mid;
    jtl_host_i.step(1'b1, 1'b1, b);
    jtl_host_i.step(1'b0, 1'b1, b);
    jtl_host_i.step(1'b0, 1'b1, b);
    jtl_host_i.step(1'b0, 1'b0, b);
    chk({31'h0, tdo_oe}, 32'h1);
    jtl_host_i.drop;
    #5;
    chk({30'h0, tdo_oe, tdo}, 32'h0);
    chk({31'h0, tdo_w}, {31'h0, 1'bz});
    jtl_host_i.reset_tap;
    jtl_host_i.scan(1'b0, 32, 32'h0, q);
    chk(q, jtl_pkg::IDCODE_VAL);
    chk(upd, 32'h1234_abcd);
    $display("test mid-shift reset done");
  endtask : test_trst_mid

  task test_five_ones;
    jtl_host_i.scan(1'b1, 4, {28'h0, jtl_pkg::OP_USERDATA}, q);
    repeat (5) jtl_host_i.step(1'b1, 1'b1, b);
    jtl_host_i.step(1'b0, 1'b1, b);
    jtl_host_i.scan(1'b0, 32, 32'h0, q);
    chk(q, jtl_pkg::IDCODE_VAL);
    $display("test five ones done");
  endtask : test_five_ones

  initial begin
    repeat (8) @(posedge clk_sys_i);
    #1 reset_i = 1'b0;
    jtl_host_i.reset_tap;
    test_idcode;
    test_bypass;
    test_user;
    test_trst_mid;
    test_five_ones;
    complete_run;
  end

  initial begin
    #100000;
    failures++;
    complete_run;
  end
endmodule : jtl_tap_tb
